// *** deep_sleep_clock_gating.sv ***
// top: clock gating registers, enable selection, bus fault and interrupt
//
// Overview of operation
// - set bit clocks unit, clear bit stops
// - access to gated unit returns bus fault
// - all gating enables reset to zero
// - separate run, sleep, deep-sleep gating registers
// - mode registers used only with auto gating
// - bits 18,17,16 gate counters 2,1,0
// - bit 12 gates two-wire unit 0
// - bit 4 gates synchronous serial 0
// - bit 0 gates asynchronous serial 0
// - reserved bits read zero, ignore writes
// - deep-sleep register at 0x124, resets zero
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_clock_gating (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // peripheral access check
  input  wire logic        unit_access,
  input  wire logic [2:0]  unit_sel,
  output logic             bus_fault,
  // gated unit clocks and enables
  output logic      [5:0]  unit_clk_en,
  output logic      [5:0]  unit_clk,
  // interrupt
  output logic             irq
);
  logic        rst_s1_q;
  logic        rst_n;
  logic [31:0] run_gate_q, run_gate_d;
  logic [31:0] sleep_gate_q, sleep_gate_d;
  logic [31:0] deep_gate_q, deep_gate_d;
  logic [31:0] run_cfg_q, run_cfg_d;
  logic [1:0]  mode_q, mode_d;
  logic [1:0]  status_q, status_d;
  logic [1:0]  mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        fault_q, fault_d;
  logic        irq_q, irq_d;
  logic [5:0]  en_prev_q;
  logic        fault_ev;
  logic        enable_ev;
  gate_sel_if  gs ();

  // =========================================================
  // reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // =========================================================
  // enable selection and clock gates
  assign gs.run_en             = clkgate_pkg::unit_bits(run_gate_q);
  assign gs.sleep_en           = clkgate_pkg::unit_bits(sleep_gate_q);
  assign gs.deep_en            = clkgate_pkg::unit_bits(deep_gate_q);
  assign gs.auto_gating_select = run_cfg_q[clkgate_pkg::AUTO_GATING_BIT];
  assign gs.power_mode         = mode_q;

  gate_enable_sel u_sel (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .gs       (gs.sel)
  );

  assign unit_clk_en = gs.unit_en;

  genvar gi;
  generate
    for (gi = 0; gi < clkgate_pkg::UNIT_COUNT; gi++) begin : g_gate
      clock_gate_cell u_cg (
        .core_clk  (core_clk),
        .enable    (gs.unit_en[gi]),
        .gated_clk (unit_clk[gi])
      );
    end
  endgenerate

  // =========================================================
  // events: fault on a gated unit, or any unit newly enabled
  assign fault_ev  = unit_access && (unit_sel < 3'(clkgate_pkg::UNIT_COUNT))
                     && !gs.unit_en[unit_sel];
  assign enable_ev = |(gs.unit_en & ~en_prev_q);

  // =========================================================
  // register writes, status set-over-clear
  always_comb begin
    run_gate_d   = run_gate_q;
    sleep_gate_d = sleep_gate_q;
    deep_gate_d  = deep_gate_q;
    run_cfg_d    = run_cfg_q;
    mode_d       = mode_q;
    mask_d       = mask_q;
    status_d     = status_q;
    if (reg_wr) begin
      unique case (reg_addr)
        clkgate_pkg::RUN_CLOCK_GATE_1_OFS:
          run_gate_d = reg_wdata & clkgate_pkg::GATE_WRITE_MASK;
        clkgate_pkg::SLEEP_CLOCK_GATE_1_OFS:
          sleep_gate_d = reg_wdata & clkgate_pkg::GATE_WRITE_MASK;
        clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS:
          deep_gate_d = reg_wdata & clkgate_pkg::GATE_WRITE_MASK;
        clkgate_pkg::RUN_CLOCK_CONFIG_OFS:
          run_cfg_d = reg_wdata & clkgate_pkg::RUN_CONFIG_MASK;
        clkgate_pkg::POWER_MODE_OFS: begin
          if (reg_wdata[1:0] != 2'h3) begin
            mode_d = reg_wdata[1:0];
          end
        end
        clkgate_pkg::IRQ_STATUS_OFS:
          status_d = status_q & ~reg_wdata[1:0];
        clkgate_pkg::IRQ_MASK_OFS:
          mask_d = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (fault_ev) begin
      status_d[clkgate_pkg::IRQ_FAULT_BIT] = 1'b1;
    end
    if (enable_ev) begin
      status_d[clkgate_pkg::IRQ_ENABLE_BIT] = 1'b1;
    end
  end

  // =========================================================
  // read data, fault and interrupt outputs
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        clkgate_pkg::RUN_CLOCK_GATE_1_OFS:        rdata_d = run_gate_q;
        clkgate_pkg::SLEEP_CLOCK_GATE_1_OFS:      rdata_d = sleep_gate_q;
        clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS: rdata_d = deep_gate_q;
        clkgate_pkg::RUN_CLOCK_CONFIG_OFS:        rdata_d = run_cfg_q;
        clkgate_pkg::POWER_MODE_OFS:              rdata_d = {30'h0, mode_q};
        clkgate_pkg::IRQ_STATUS_OFS:              rdata_d = {30'h0, status_q};
        clkgate_pkg::IRQ_MASK_OFS:                rdata_d = {30'h0, mask_q};
        default:                                  rdata_d = 32'h0000_0000;
      endcase
    end
    fault_d = fault_ev;
    irq_d   = |(status_d & mask_d);
  end

  // registers, all zero after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_gate_q   <= clkgate_pkg::GATE_RESET;
      sleep_gate_q <= clkgate_pkg::GATE_RESET;
      deep_gate_q  <= clkgate_pkg::GATE_RESET;
      run_cfg_q    <= clkgate_pkg::RUN_CONFIG_RESET;
      mode_q       <= clkgate_pkg::MODE_RUN;
      status_q     <= 2'h0;
      mask_q       <= 2'h0;
      rdata_q      <= 32'h0000_0000;
      fault_q      <= 1'b0;
      irq_q        <= 1'b0;
      en_prev_q    <= 6'h00;
    end else begin
      run_gate_q   <= run_gate_d;
      sleep_gate_q <= sleep_gate_d;
      deep_gate_q  <= deep_gate_d;
      run_cfg_q    <= run_cfg_d;
      mode_q       <= mode_d;
      status_q     <= status_d;
      mask_q       <= mask_d;
      rdata_q      <= rdata_d;
      fault_q      <= fault_d;
      irq_q        <= irq_d;
      en_prev_q    <= gs.unit_en;
    end
  end

  assign reg_rdata = rdata_q;
  assign bus_fault = fault_q;
  assign irq       = irq_q;

  // =========================================================
  // checks
  sequence deep_write_s;
    reg_wr && reg_addr == clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS;
  endsequence
  sequence deep_read_s;
    reg_rd && reg_addr == clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS;
  endsequence

  AST_FAULT_ON_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
    unit_access && unit_sel < 3'h6 && !gs.unit_en[unit_sel] |=> bus_fault)
    else $error("no bus fault for gated unit");
  AST_NO_FAULT_ENABLED: assert property (@(posedge core_clk) disable iff (!rst_n)
    unit_access && unit_sel < 3'h6 && gs.unit_en[unit_sel] |=> !bus_fault)
    else $error("bus fault for clocked unit");
  AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    (deep_gate_q & ~clkgate_pkg::GATE_WRITE_MASK) == 32'h0)
    else $error("reserved deep-sleep bit set");
  AST_DEEP_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    deep_write_s ##1 deep_read_s |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0007_1011))
    else $error("deep-sleep readback wrong");
  AST_RUN_WITHOUT_AUTO: assert property (@(posedge core_clk) disable iff (!rst_n)
    !gs.auto_gating_select ##1 !gs.auto_gating_select |-> unit_clk_en == $past(gs.run_en))
    else $error("mode register used without auto gating");
  AST_DEEP_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
    gs.auto_gating_select && mode_q == 2'h2 |=> unit_clk_en == $past(gs.deep_en))
    else $error("deep-sleep enables not applied");
  AST_SLEEP_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
    gs.auto_gating_select && mode_q == 2'h1 |=> unit_clk_en == $past(gs.sleep_en))
    else $error("sleep enables not applied");
  AST_COUNTER2_BIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    gs.deep_en[5] == deep_gate_q[18] && gs.deep_en[3] == deep_gate_q[16])
    else $error("counter gate bit misplaced");
  AST_SERIAL_BITS: assert property (@(posedge core_clk) disable iff (!rst_n)
    gs.run_en[2] == run_gate_q[12] && gs.run_en[1] == run_gate_q[4]
    && gs.run_en[0] == run_gate_q[0])
    else $error("serial gate bit misplaced");
  AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == |(status_q & mask_q))
    else $error("interrupt level wrong");
  AST_RESET_ZERO: assert property (@(posedge core_clk)
    $rose(rst_n) |-> deep_gate_q == 32'h0 && run_gate_q == 32'h0)
    else $error("gating not zero after reset");
endmodule
`default_nettype wire

// *** clkgate_pkg.sv ***
// package: offsets, field positions, reset values and mode codes for clock gating
package clkgate_pkg;

  // =========================================================
  // register map (byte offsets from the system control base)
  localparam logic [11:0] RUN_CLOCK_GATE_1_OFS        = 12'h104;
  localparam logic [11:0] SLEEP_CLOCK_GATE_1_OFS      = 12'h114;
  localparam logic [11:0] DEEP_SLEEP_CLOCK_GATE_1_OFS = 12'h124;
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFS        = 12'h060;
  localparam logic [11:0] POWER_MODE_OFS              = 12'h200;
  localparam logic [11:0] IRQ_STATUS_OFS              = 12'h204;
  localparam logic [11:0] IRQ_MASK_OFS                = 12'h208;
  localparam logic [31:0] SYSCTL_BASE                 = 32'h400f_e000;

  // =========================================================
  // gating register fields
  localparam int          GATE_COUNTER2_BIT = 18;
  localparam int          GATE_COUNTER1_BIT = 17;
  localparam int          GATE_COUNTER0_BIT = 16;
  localparam int          GATE_TWOWIRE0_BIT = 12;
  localparam int          GATE_SYNCSER0_BIT = 4;
  localparam int          GATE_ASYNC0_BIT   = 0;
  localparam logic [31:0] GATE_WRITE_MASK   = 32'h0007_1011;
  localparam logic [31:0] GATE_RESET        = 32'h0000_0000;
  localparam int          UNIT_COUNT        = 6;

  // =========================================================
  // run clock config, power mode and interrupt fields
  localparam int          AUTO_GATING_BIT   = 27;
  localparam logic [31:0] RUN_CONFIG_MASK   = 32'h0800_0000;
  localparam logic [31:0] RUN_CONFIG_RESET  = 32'h0000_0000;
  localparam logic [1:0]  MODE_RUN          = 2'h0;
  localparam logic [1:0]  MODE_SLEEP        = 2'h1;
  localparam logic [1:0]  MODE_DEEP_SLEEP   = 2'h2;
  localparam int          IRQ_FAULT_BIT     = 0;
  localparam int          IRQ_ENABLE_BIT    = 1;
  localparam logic [31:0] IRQ_FIELD_MASK    = 32'h0000_0003;

  // position of each unit's enable in the gating register
  function automatic logic [UNIT_COUNT-1:0] unit_bits(input logic [31:0] r);
    unit_bits = {r[GATE_COUNTER2_BIT], r[GATE_COUNTER1_BIT], r[GATE_COUNTER0_BIT],
                 r[GATE_TWOWIRE0_BIT], r[GATE_SYNCSER0_BIT], r[GATE_ASYNC0_BIT]};
  endfunction

endpackage

// *** gate_sel_if.sv ***
// interface: gating register contents and mode handed to the enable selector
`timescale 1ns/1ps
`default_nettype none
interface gate_sel_if;
  logic [5:0] run_en;
  logic [5:0] sleep_en;
  logic [5:0] deep_en;
  logic       auto_gating_select;
  logic [1:0] power_mode;
  logic [5:0] unit_en;
  modport regs (output run_en, sleep_en, deep_en, auto_gating_select, power_mode,
                input unit_en);
  modport sel  (input run_en, sleep_en, deep_en, auto_gating_select, power_mode,
                output unit_en);
endinterface
`default_nettype wire

// *** gate_enable_sel.sv ***
// module: picks each unit's clock enable from the run, sleep or deep-sleep register
`timescale 1ns/1ps
`default_nettype none
module gate_enable_sel (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // register side
  gate_sel_if.sel   gs
);
  logic [5:0] en_d;
  logic [5:0] en_q;

  // =========================================================
  // selection: mode registers only apply with auto gating
  always_comb begin
    en_d = gs.run_en;
    if (gs.auto_gating_select) begin
      unique case (gs.power_mode)
        clkgate_pkg::MODE_SLEEP:      en_d = gs.sleep_en;
        clkgate_pkg::MODE_DEEP_SLEEP: en_d = gs.deep_en;
        default:                      en_d = gs.run_en;
      endcase
    end
  end

  // registered so the downstream gate cells see a stable enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 6'h00;
    end else begin
      en_q <= en_d;
    end
  end

  assign gs.unit_en = en_q;
endmodule
`default_nettype wire

// *** clock_gate_cell.sv ***
// module: latch-based glitch-free clock gate for one unit
`timescale 1ns/1ps
`default_nettype none
module clock_gate_cell (
  // clock
  input  wire logic core_clk,
  // enable
  input  wire logic enable,
  // gated clock
  output logic      gated_clk
);
  logic en_lat;

  // latch transparent while clock low, so enable changes never chop a pulse
  always_latch begin
    if (!core_clk) begin
      en_lat = enable;
    end
  end

  assign gated_clk = core_clk & en_lat;
endmodule
`default_nettype wire

// *** test_deep_sleep_clock_gating.sv ***
// testbench: register, gating, fault and interrupt checks for the clock gating block
`timescale 1ns/1ps
`default_nettype none
module test_deep_sleep_clock_gating;
  // =========================================================
  // stimulus and observed signals
  logic        core_clk = 1'b0;
  logic        resetn;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        unit_access = 1'b0;
  logic [2:0]  unit_sel = 3'h0;
  logic        bus_fault;
  logic [5:0]  unit_clk_en;
  logic [5:0]  unit_clk;
  logic        irq;
  int          miscompares = 0;
  int          n_compared = 0;
  int          edges [6] = '{default: 0};
  int          pos [6] = '{0, 4, 12, 16, 17, 18};
  int          snap;

  deep_sleep_clock_gating uut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .unit_access(unit_access),
    .unit_sel(unit_sel), .bus_fault(bus_fault), .unit_clk_en(unit_clk_en),
    .unit_clk(unit_clk), .irq(irq));

  // 40 mhz clock
  always #12.5 core_clk = ~core_clk;

  // count gated clock edges per unit
  for (genvar g = 0; g < 6; g++) begin : g_cnt
    always @(posedge unit_clk[g]) edges[g]++;
  end

  // =========================================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check("rdata", reg_rdata & msk, exp);
  endtask

  task automatic access(input logic [2:0] s, input logic exp);
    @(posedge core_clk);
    unit_access <= 1'b1;
    unit_sel <= s;
    @(posedge core_clk);
    unit_access <= 1'b0;
    #1;
    check("bus_fault", {31'h0, bus_fault}, {31'h0, exp});
  endtask

  task automatic en_is(input logic [5:0] exp);
    @(posedge core_clk);
    #1;
    check("unit_clk_en", {26'h0, unit_clk_en}, {26'h0, exp});
  endtask

  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(25 * 4000);
    miscompares++;
    summarize();
  end

  // =========================================================
  // test sequence
  initial begin
    // driven from unknown to low so the asynchronous reset sees a falling edge
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    // reset values
    rd(clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000, 32'hffff_ffff);
    rd(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h0000_0000, 32'hffff_ffff);
    rd(clkgate_pkg::SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000, 32'hffff_ffff);
    check("reset en", {26'h0, unit_clk_en}, 32'h0000_0000);
    // reserved bits read zero, writable bits keep ones
    wr(clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'hffff_ffff);
    rd(clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0007_1011, 32'hffff_ffff);
    wr(clkgate_pkg::SLEEP_CLOCK_GATE_1_OFS, 32'hfff8_efee);
    rd(clkgate_pkg::SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000, 32'hffff_ffff);
    // every unit gated: all fault, spare indices never
    for (int i = 0; i < 8; i++) access(3'(i), i < 6);
    // one unit at a time through the run register
    for (int i = 0; i < 6; i++) begin
      wr(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h1 << pos[i]);
      en_is(6'h1 << i);
      rd(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h1 << pos[i], 32'hffff_ffff);
      snap = edges[i];
      repeat (4) @(posedge core_clk);
      #1;
      check("gated edges", 32'(edges[i] - snap), 32'h0000_0004);
      access(3'(i), 1'b0);
      access(3'((i + 1) % 6), 1'b1);
    end
    snap = edges[0];
    repeat (4) @(posedge core_clk);
    check("stopped edges", 32'(edges[0] - snap), 32'h0000_0000);
    // mode selection with and without auto gating
    wr(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h0001_0000);
    wr(clkgate_pkg::SLEEP_CLOCK_GATE_1_OFS, 32'h0000_1000);
    wr(clkgate_pkg::POWER_MODE_OFS, 32'(clkgate_pkg::MODE_DEEP_SLEEP));
    en_is(6'h08);
    wr(clkgate_pkg::RUN_CLOCK_CONFIG_OFS, 32'hffff_ffff);
    en_is(6'h3f);
    rd(clkgate_pkg::RUN_CLOCK_CONFIG_OFS, 32'h0800_0000, 32'hffff_ffff);
    wr(clkgate_pkg::POWER_MODE_OFS, 32'(clkgate_pkg::MODE_SLEEP));
    en_is(6'h04);
    wr(clkgate_pkg::POWER_MODE_OFS, 32'h0000_0003);
    en_is(6'h04);
    wr(clkgate_pkg::POWER_MODE_OFS, 32'(clkgate_pkg::MODE_RUN));
    en_is(6'h08);
    wr(clkgate_pkg::RUN_CLOCK_CONFIG_OFS, 32'h0000_0000);
    // fault interrupt: raise, clear, mask
    wr(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h0000_0000);
    wr(clkgate_pkg::IRQ_MASK_OFS, 32'h0000_0001);
    wr(clkgate_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
    en_is(6'h00);
    access(3'h0, 1'b1);
    en_is(6'h00);
    check("irq set", {31'h0, irq}, 32'h0000_0001);
    rd(clkgate_pkg::IRQ_STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    wr(clkgate_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
    en_is(6'h00);
    check("irq clear", {31'h0, irq}, 32'h0000_0000);
    wr(clkgate_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    access(3'h5, 1'b1);
    en_is(6'h00);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    // newly enabled unit sets the second status bit
    wr(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h0000_0001);
    wr(clkgate_pkg::IRQ_MASK_OFS, 32'h0000_0002);
    en_is(6'h01);
    check("irq enable", {31'h0, irq}, 32'h0000_0001);
    rd(clkgate_pkg::IRQ_STATUS_OFS, 32'h0000_0003, 32'h0000_0003);
    // unmapped address ignores writes, reads zero
    wr(12'h300, 32'hffff_ffff);
    rd(12'h300, 32'h0000_0000, 32'hffff_ffff);
    rd(clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0007_1011, 32'hffff_ffff);
    // write then read with no gap between the strobes
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS;
    reg_wdata <= 32'hffff_fffe;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check("back to back", reg_rdata, 32'h0007_1010);
    // second reset in mid-run: deep-sleep and run registers, enables and irq back to zero
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(clkgate_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000, 32'hffff_ffff);
    rd(clkgate_pkg::RUN_CLOCK_GATE_1_OFS, 32'h0000_0000, 32'hffff_ffff);
    check("reset en again", {26'h0, unit_clk_en}, 32'h0000_0000);
    check("reset irq", {31'h0, irq}, 32'h0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
